// [core/mft_pkg.sv]
/*
  Constants, carriers and helper functions for the multi_function_timer host sequencer.
  Assumes the timer's registers are reached by byte writes at the indexes below.
*/
package mft_pkg;
  localparam int         NCH            = 5;
  // Register indexes on the device write port
  localparam logic [7:0] ADDR_START     = 8'h00;
  localparam logic [7:0] ADDR_OUT_EN    = 8'h01;
  localparam logic [7:0] ADDR_OUT_CTRL  = 8'h02;
  localparam logic [7:0] ADDR_MODE_BASE = 8'h10;
  localparam logic [7:0] ADDR_IOC_BASE  = 8'h20;
  localparam logic [7:0] ADDR_IRQ_BASE  = 8'h30;
  // Mode field codes, buffer bits sit above them
  localparam logic [2:0] MODE_NORMAL    = 3'h0;
  localparam logic [2:0] MODE_PULSE1    = 3'h2;
  localparam logic [2:0] MODE_PULSE2    = 3'h3;
  localparam logic [2:0] MODE_PHASE     = 3'h4;
  localparam logic [2:0] MODE_COMPL     = 3'h5;
  localparam logic [2:0] MODE_RSYNC     = 3'h6;
  localparam logic [2:0] MODE_RESET     = MODE_NORMAL;
  localparam int         MODE_BUF_LSB   = 4;
  localparam logic [7:0] IOC_LOW_INIT   = 8'h11;
  localparam logic [7:0] IOC_IDLE       = 8'h00;
  localparam logic [7:0] OUT_EN_ALL     = 8'h3F;
  localparam logic [7:0] OUT_EN_NONE    = 8'h00;
  localparam logic [7:0] IRQ_CD_MASK    = 8'h0C;
  localparam logic [7:0] IRQ_NONE       = 8'h00;
  localparam logic [4:0] CH_NONE        = 5'h00;
  localparam logic [4:0] CH_PAIR        = 5'h18;

  typedef struct packed {
    logic [2:0] chan;
    logic [2:0] mode;
    logic [1:0] buf_cd;
    logic [7:0] io_init;
    logic [7:0] out_ctrl;
    logic [7:0] irq_en;
  } mft_cmd_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } mft_wr_t;

  function automatic logic mft_is_pair(input logic [2:0] m);
    return (m == MODE_COMPL) || (m == MODE_RSYNC);
  endfunction

  function automatic logic mft_mode_ok(input logic [2:0] ch, input logic [2:0] m);
    if (ch > 3'h4) return 1'b0;
    else if (m == MODE_NORMAL || m == MODE_PULSE1) return 1'b1;
    else if (m == MODE_PULSE2) return ch <= 3'h2;
    else if (m == MODE_PHASE) return ch == 3'h1 || ch == 3'h2;
    else if (mft_is_pair(m)) return ch >= 3'h3;
    else return 1'b0;
  endfunction

  function automatic logic mft_trans_ok(input logic [2:0] from, input logic [2:0] to);
    logic far_from;
    logic far_to;
    far_from = (from == MODE_PULSE2) || (from == MODE_PHASE);
    far_to   = (to == MODE_PULSE2) || (to == MODE_PHASE);
    return !((far_from && mft_is_pair(to)) || (mft_is_pair(from) && far_to));
  endfunction

  function automatic logic [4:0] mft_ch_mask(input logic [2:0] ch, input logic pair);
    if (pair) return CH_PAIR;
    else return 5'(5'h01 << ch);
  endfunction
endpackage

// [core/mft_wr_port.sv]
/*
  Holding stage for one register write toward the timer.
  Assumes the timer takes a write when dev_wr_valid and dev_wr_ready are both high.
*/
`timescale 1ns/1ps
module mft_wr_port
  import mft_pkg::*;
(
  input  wire logic    clk_sys,
  input  wire logic    reset,
  input  wire logic    wr_go,
  input  mft_wr_t      wr_in,
  output logic         wr_busy,
  output logic         dev_wr_valid,
  output mft_wr_t      dev_wr,
  input  wire logic    dev_wr_ready
);
  // ==========================================================
  // Pending write
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      dev_wr_valid <= 1'b0;
    end else if (wr_go && !dev_wr_valid) begin
      dev_wr_valid <= 1'b1;
    end else if (dev_wr_ready) begin
      dev_wr_valid <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      dev_wr <= '0;
    end else if (wr_go && !dev_wr_valid) begin
      dev_wr <= wr_in;
    end
  end

  assign wr_busy = dev_wr_valid;
endmodule // mft_wr_port

// [core/mft_init_ctrl.sv]
/*
  Host sequencer that cuts, re-initialises and restarts timer channels on command.
  Assumes the timer's register write port, its pin function mux and port drivers outside.
*/
`timescale 1ns/1ps
module mft_init_ctrl
  import mft_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       cmd_valid,
  input  mft_cmd_t        cmd,
  output logic            cmd_ready,
  output logic            cmd_done,
  output logic            cmd_reject,
  input  wire logic       error_in,
  input  wire logic [4:0] active_low,
  input  wire logic       standby_req,
  output logic            standby_en,
  output logic [4:0]      pin_timer_sel,
  output logic [4:0]      port_level,
  output logic            dev_wr_valid,
  output mft_wr_t         dev_wr,
  input  wire logic       dev_wr_ready
);
  typedef enum {
    S_IDLE, S_CUT, S_STOP, S_PRE_MODE, S_OE_ON, S_IOC, S_IOC_ZERO, S_OE_OFF,
    S_OCR, S_IRQ_OFF, S_MODE, S_OE_ON2, S_SELECT, S_START, S_IRQ_ALL, S_STBY
  } mft_state_t;

  mft_state_t state;
  mft_state_t next_state;
  mft_cmd_t   cur;
  logic [2:0] ch_mode [NCH];
  logic [4:0] run_mask;
  logic [2:0] idx;
  logic       pair;
  logic       need_norm;
  logic [4:0] chm;
  logic       wr_go;
  logic       wr_busy;
  mft_wr_t    wr_req;
  logic       accept;
  logic       legal;
  logic       last_idx;

  assign pair      = mft_is_pair(cur.mode);
  assign need_norm = pair || cur.mode == MODE_PULSE1 || cur.mode == MODE_PULSE2
                     || cur.buf_cd != 2'b00;
  assign chm       = mft_ch_mask(cur.chan, pair);
  assign legal     = mft_mode_ok(cmd.chan, cmd.mode)
                     && mft_trans_ok(ch_mode[cmd.chan], cmd.mode);
  assign cmd_ready = state == S_IDLE && !standby_req;
  assign accept    = cmd_valid && cmd_ready;
  assign port_level = active_low;
  assign last_idx  = pair ? (idx == 3'h3) : (idx == 3'h1);

  // ==========================================================
  // Write selection and next state
  always_comb begin
    wr_go      = 1'b0;
    wr_req     = '0;
    next_state = state;
    case (state)
      S_IDLE: begin
        if (standby_req && !standby_en) next_state = S_IRQ_ALL;
        else if (accept && legal) next_state = S_CUT;
      end
      S_CUT: next_state = S_STOP;
      S_STOP: begin
        wr_go      = 1'b1;
        wr_req     = '{ADDR_START, {3'b000, run_mask & ~chm}};
        next_state = S_PRE_MODE;
      end
      S_PRE_MODE: begin
        wr_go      = 1'b1;
        wr_req     = '{ADDR_MODE_BASE + 8'(cur.chan),
                       need_norm ? {5'b0, MODE_NORMAL} : {5'b0, cur.mode}};
        next_state = (cur.chan >= 3'h3) ? S_OE_ON : S_IOC;
      end
      S_OE_ON: begin
        wr_go      = 1'b1;
        wr_req     = '{ADDR_OUT_EN, OUT_EN_ALL};
        next_state = S_IOC;
      end
      S_IOC: begin
        wr_go  = 1'b1;
        wr_req = pair ? mft_wr_t'{ADDR_IOC_BASE + 8'h06 + 8'(idx), IOC_LOW_INIT}
                      : mft_wr_t'{ADDR_IOC_BASE + {4'b0, cur.chan, 1'b0} + 8'(idx), cur.io_init};
        if (last_idx) next_state = pair ? S_IOC_ZERO
                                        : (need_norm ? S_IRQ_OFF : S_SELECT);
      end
      S_IOC_ZERO: begin
        wr_go  = 1'b1;
        wr_req = '{ADDR_IOC_BASE + 8'h06 + 8'(idx), IOC_IDLE};
        if (last_idx) next_state = S_OE_OFF;
      end
      S_OE_OFF: begin
        wr_go      = 1'b1;
        wr_req     = '{ADDR_OUT_EN, OUT_EN_NONE};
        next_state = S_OCR;
      end
      S_OCR: begin
        wr_go      = 1'b1;
        wr_req     = '{ADDR_OUT_CTRL, cur.out_ctrl};
        next_state = S_IRQ_OFF;
      end
      S_IRQ_OFF: begin
        wr_go      = 1'b1;
        wr_req     = '{ADDR_IRQ_BASE + 8'(cur.chan),
                       cur.buf_cd != 2'b00 ? (cur.irq_en & ~IRQ_CD_MASK) : cur.irq_en};
        next_state = S_MODE;
      end
      S_MODE: begin
        wr_go      = 1'b1;
        wr_req     = '{ADDR_MODE_BASE + 8'(cur.chan),
                       {2'b00, cur.buf_cd, 1'b0, cur.mode}};
        next_state = pair ? S_OE_ON2 : S_SELECT;
      end
      S_OE_ON2: begin
        wr_go      = 1'b1;
        wr_req     = '{ADDR_OUT_EN, OUT_EN_ALL};
        next_state = S_SELECT;
      end
      S_SELECT: if (!wr_busy) next_state = S_START;
      S_START: begin
        wr_go      = 1'b1;
        wr_req     = '{ADDR_START, {3'b000, run_mask | chm}};
        next_state = S_IDLE;
      end
      S_IRQ_ALL: begin
        wr_go      = 1'b1;
        wr_req     = '{ADDR_IRQ_BASE + 8'(idx), IRQ_NONE};
        if (idx == 3'(NCH - 1)) next_state = S_STBY;
      end
      S_STBY: if (!wr_busy) next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
    if (wr_go && wr_busy) next_state = state;
  end

  // ==========================================================
  // Sequencer state
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) state <= S_IDLE;
    else       state <= next_state;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      idx <= 3'h0;
    end else if (state != next_state) begin
      idx <= 3'h0;
    end else if (wr_go && !wr_busy) begin
      idx <= idx + 3'h1;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) cur <= '0;
    else if (accept) cur <= cmd;
  end

  // Shadow of each channel's mode, normal after reset
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NCH; i++) ch_mode[i] <= MODE_RESET;
    end else if (state == S_START && !wr_busy) begin
      for (int i = 0; i < NCH; i++) begin
        if (chm[i]) ch_mode[i] <= cur.mode;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      run_mask <= CH_NONE;
    end else if (wr_go && !wr_busy && state == S_STOP) begin
      run_mask <= run_mask & ~chm;
    end else if (wr_go && !wr_busy && state == S_START) begin
      run_mask <= run_mask | chm;
    end
  end

  // Pin mux: port until initialised, cut at once on error
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pin_timer_sel <= CH_NONE;
    end else if (error_in) begin
      pin_timer_sel <= CH_NONE;
    end else if (state == S_CUT) begin
      pin_timer_sel <= pin_timer_sel & ~chm;
    end else if (state == S_SELECT && !wr_busy) begin
      pin_timer_sel <= pin_timer_sel | chm;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      standby_en <= 1'b0;
    end else if (state == S_STBY && !wr_busy) begin
      standby_en <= 1'b1;
    end else if (!standby_req) begin
      standby_en <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cmd_done   <= 1'b0;
      cmd_reject <= 1'b0;
    end else begin
      cmd_done   <= state == S_START && !wr_busy;
      cmd_reject <= accept && !legal && !(standby_req && !standby_en);
    end
  end

  mft_wr_port u_wr_port (
    .clk_sys      (clk_sys),
    .reset        (reset),
    .wr_go        (wr_go),
    .wr_in        (wr_req),
    .wr_busy      (wr_busy),
    .dev_wr_valid (dev_wr_valid),
    .dev_wr       (dev_wr),
    .dev_wr_ready (dev_wr_ready)
  );

  // ==========================================================
  // Checks
  logic oe_on_seen;
  logic low_seen;
  logic ocr_seen;
  logic irq_seen;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      oe_on_seen <= 1'b0;
      low_seen   <= 1'b0;
      ocr_seen   <= 1'b0;
      irq_seen   <= 1'b0;
    end else if (state == S_IDLE) begin
      oe_on_seen <= 1'b0;
      low_seen   <= 1'b0;
      ocr_seen   <= 1'b0;
      irq_seen   <= standby_en ? irq_seen : 1'b0;
    end else if (wr_go && !wr_busy) begin
      if (state == S_OE_ON) oe_on_seen <= 1'b1;
      if (state == S_IOC && last_idx) low_seen <= 1'b1;
      if (state == S_OCR) ocr_seen <= 1'b1;
      if (state == S_IRQ_OFF || (state == S_IRQ_ALL && idx == 3'(NCH - 1))) irq_seen <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  chk_error_cut: assert property (error_in |=> pin_timer_sel == CH_NONE)
    else $error("pins not cut after error");
  chk_low_first: assert property (state == S_IOC_ZERO |-> low_seen)
    else $error("zero io control before low init");
  chk_pair_mode: assert property (state == S_MODE && pair && wr_go |-> ocr_seen && oe_on_seen)
    else $error("pair mode set before output control");
  chk_oe_before_io: assert property (state == S_IOC && cur.chan >= 3'h3 |-> oe_on_seen)
    else $error("io control before output enable");
  chk_standby_irq: assert property ($rose(standby_en) |-> irq_seen)
    else $error("standby with irq enabled");
  chk_buf_irq: assert property (state == S_MODE && cur.buf_cd != 2'b00 |-> irq_seen)
    else $error("buffer mode without irq clear");
  chk_illegal_cmd: assert property (accept && !legal && !standby_req |=> state == S_IDLE && cmd_reject)
    else $error("illegal mode accepted");
  chk_select_late: assert property ($rose(|pin_timer_sel) |-> $past(state == S_SELECT) && !$past(wr_busy))
    else $error("timer output selected early");
  chk_stop_first: assert property (state == S_PRE_MODE |-> (run_mask & chm) == CH_NONE && (pin_timer_sel & chm) == CH_NONE)
    else $error("mode change while running");
  chk_done_once: assert property (state == S_START && !wr_busy |=> cmd_done ##1 !cmd_done)
    else $error("done pulse wrong");

  cov_pair_entry: cover property (state == S_OE_ON2 ##[1:20] cmd_done);
  cov_reject:     cover property (cmd_reject);
  cov_standby:    cover property ($rose(standby_en));
  cov_error_cut:  cover property (error_in && pin_timer_sel != CH_NONE);
endmodule // mft_init_ctrl

// [verif/mft_dev_model.sv]
/*
  Behavioural model of the timer's register file, waveform pins and pin mux.
  Assumes one byte write per valid/ready handshake from the host sequencer.
*/
`timescale 1ns/1ps
module mft_dev_model
  import mft_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       slow,
  input  wire logic       standby_en,
  input  wire logic [4:0] pin_timer_sel,
  input  wire logic [4:0] port_level,
  input  wire logic       dev_wr_valid,
  input  mft_wr_t         dev_wr,
  output logic            dev_wr_ready,
  output logic [4:0]      pin_out
);
  logic [7:0] regs [0:63];
  logic [4:0] wave;
  logic [1:0] cnt;
  logic       take;

  assign take = dev_wr_valid && dev_wr_ready;

  // ==========================================
  // Write port, stalls three cycles in four when slow
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt          <= 2'h0;
      dev_wr_ready <= 1'b0;
    end else begin
      cnt          <= cnt + 2'h1;
      dev_wr_ready <= !slow || (cnt == 2'h2);
    end
  end

  // ==========================================
  // Registers, all modes normal after reset
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 64; i++) regs[i] <= 8'h00;
    end else if (take) begin
      regs[dev_wr.addr[5:0]] <= dev_wr.data;
    end
  end

  // ==========================================
  // Waveform pins: low in reset and standby, hold while stopped
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) wave <= 5'h00;
    else if (standby_en) wave <= 5'h00;
    else wave <= wave ^ regs[0][4:0];
  end

  assign pin_out = (pin_timer_sel & wave) | (~pin_timer_sel & port_level);
endmodule // mft_dev_model

// [verif/test_mft_init_ctrl.sv]
/*
  Self-checking bench for the host sequencer with a device model behind it.
  Assumes a 20 MHz clock and active-high asynchronous reset.
*/
`timescale 1ns/1ps
module test_mft_init_ctrl;
  import mft_pkg::*;
  typedef struct packed {
    mft_cmd_t cmd;
    logic     rej;
  } mft_row_t;

  logic        clk_sys, reset, cmd_valid, cmd_ready, cmd_done, cmd_reject, error_in;
  logic        standby_req, standby_en, dev_wr_valid, dev_wr_ready, slow;
  logic [4:0]  active_low, pin_timer_sel, port_level, pin_out, cur_mask;
  mft_cmd_t    cmd;
  mft_wr_t     dev_wr;
  logic [15:0] log_q[$];
  int          errors, cmp_count, cycles;
  mft_row_t    rows [10];

  mft_init_ctrl DUT (.clk_sys(clk_sys), .reset(reset), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .cmd_done(cmd_done), .cmd_reject(cmd_reject), .error_in(error_in),
    .active_low(active_low), .standby_req(standby_req), .standby_en(standby_en),
    .pin_timer_sel(pin_timer_sel), .port_level(port_level), .dev_wr_valid(dev_wr_valid),
    .dev_wr(dev_wr), .dev_wr_ready(dev_wr_ready));
  mft_dev_model DEV (.clk_sys(clk_sys), .reset(reset), .slow(slow), .standby_en(standby_en),
    .pin_timer_sel(pin_timer_sel), .port_level(port_level), .dev_wr_valid(dev_wr_valid),
    .dev_wr(dev_wr), .dev_wr_ready(dev_wr_ready), .pin_out(pin_out));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // ==========================================
  // Write monitor and hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      summarize();
    end
    if (!reset && dev_wr_valid && dev_wr_ready) begin
      log_q.push_back(dev_wr);
      if (dev_wr.addr[7:4] == 4'h2) chk(16'(pin_timer_sel & cur_mask), 16'h0000);
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    chk(16'(got), 16'(exp));
  endtask

  task automatic summarize();
    if (errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  function automatic int find(input logic [15:0] w, input int from);
    for (int i = from; i < log_q.size(); i++) if (log_q[i] === w) return i;
    return 9999;
  endfunction

  task automatic send(input mft_cmd_t c, output logic rej);
    int n;
    n = 0;
    cmd <= c;
    cmd_valid <= 1'b1;
    @(posedge clk_sys);
    while (cmd_ready !== 1'b1 && n < 100) begin
      n++;
      @(posedge clk_sys);
    end
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (cmd_done !== 1'b1 && cmd_reject !== 1'b1 && n < 400);
    rej = cmd_reject;
    chk_flag(cmd_done ^ cmd_reject, 1'b1);
    n = 0;
    while (dev_wr_valid !== 1'b0 && n < 20) begin
      n++;
      @(posedge clk_sys);
    end
    @(posedge clk_sys);
  endtask

  initial begin
    mft_cmd_t   c;
    logic       rej, pair, need;
    logic [4:0] m;
    logic [7:0] ma, ia, fin;
    int         base, im;
    rows = '{
      '{'{3'h0, MODE_NORMAL, 2'h0, 8'hA5, 8'h00, 8'h00}, 1'b0},
      '{'{3'h1, MODE_PHASE,  2'h0, 8'h22, 8'h00, 8'h00}, 1'b0},
      '{'{3'h2, MODE_PULSE2, 2'h3, 8'h5A, 8'h00, 8'hFF}, 1'b0},
      '{'{3'h4, MODE_PULSE1, 2'h2, 8'h33, 8'h00, 8'h05}, 1'b0},
      '{'{3'h3, MODE_PULSE2, 2'h0, 8'h00, 8'h00, 8'h00}, 1'b1},
      '{'{3'h0, MODE_PHASE,  2'h0, 8'h00, 8'h00, 8'h00}, 1'b1},
      '{'{3'h1, MODE_COMPL,  2'h0, 8'h00, 8'h00, 8'h00}, 1'b1},
      '{'{3'h5, MODE_NORMAL, 2'h0, 8'h00, 8'h00, 8'h00}, 1'b1},
      '{'{3'h3, MODE_RSYNC,  2'h0, 8'h00, 8'h3C, 8'h0F}, 1'b0},
      '{'{3'h4, MODE_COMPL,  2'h1, 8'h00, 8'h2D, 8'h0C}, 1'b0}};
    {cmd_valid, error_in, standby_req, slow, cycles, errors, cmp_count} = '0;
    cmd = '0;
    active_low = 5'h00;
    cur_mask = 5'h00;
    reset = 1'b1;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    chk(16'(pin_timer_sel), 16'h0000);
    // ==========================================
    // Table of commands
    foreach (rows[i]) begin
      c = rows[i].cmd;
      pair = (c.mode == MODE_COMPL) || (c.mode == MODE_RSYNC);
      need = pair || c.mode == MODE_PULSE1 || c.mode == MODE_PULSE2 || c.buf_cd != 2'h0;
      m = pair ? CH_PAIR : 5'(5'h01 << c.chan);
      ma = ADDR_MODE_BASE + 8'(c.chan);
      ia = pair ? 8'h26 : ADDR_IOC_BASE + 8'({c.chan, 1'b0});
      fin = {2'h0, c.buf_cd, 1'b0, c.mode};
      cur_mask <= m;
      slow <= i[0];
      base = log_q.size();
      send(c, rej);
      chk_flag(rej, rows[i].rej);
      if (rows[i].rej) chk(16'(log_q.size() - base), 16'h0000);
      else begin
        chk(16'(log_q[base][15:8]), 16'(ADDR_START));
        chk(16'(log_q[$][15:8]), 16'(ADDR_START));
        chk(16'(DEV.regs[0][4:0] & m), 16'(m));
        chk(16'(pin_timer_sel & m), 16'(m));
        chk(16'(DEV.regs[ma[5:0]]), 16'(fin));
        if (need) chk(16'(DEV.regs[6'h30 + 6'(c.chan)]),
          16'(c.irq_en & ((c.buf_cd != 2'h0) ? 8'hF3 : 8'hFF)));
        if (pair) begin
          for (int j = 6; j < 10; j++) chk(16'(DEV.regs[6'h20 + 6'(j)]), 16'h0000);
          chk(16'(DEV.regs[1]), 16'(OUT_EN_ALL));
          chk(16'(DEV.regs[2]), 16'(c.out_ctrl));
          im = find({ma, fin}, base);
          chk_flag(find({ADDR_OUT_EN, OUT_EN_ALL}, base) < find({ia, IOC_LOW_INIT}, base), 1'b1);
          chk_flag(find({ia, IOC_LOW_INIT}, base) < find({ia, IOC_IDLE}, base), 1'b1);
          chk_flag(find({ia, IOC_IDLE}, base) < im, 1'b1);
          chk_flag(find({ADDR_OUT_EN, OUT_EN_NONE}, base) < find({ADDR_OUT_CTRL, c.out_ctrl}, base)
            && find({ADDR_OUT_CTRL, c.out_ctrl}, base) < im, 1'b1);
          chk_flag(find({ADDR_OUT_EN, OUT_EN_ALL}, im) < 9999, 1'b1);
        end else begin
          chk(16'(DEV.regs[ia[5:0]]), 16'(c.io_init));
          chk(16'(DEV.regs[ia[5:0] + 6'h01]), 16'(c.io_init));
          if (need) chk_flag(find({ma, 8'h00}, base) < find({ia, c.io_init}, base)
            && find({ia, c.io_init}, base) < find({ma, fin}, base), 1'b1);
        end
      end
    end
    // ==========================================
    // Error cut and recovery
    active_low <= 5'h15;
    error_in <= 1'b1;
    @(posedge clk_sys);
    error_in <= 1'b0;
    @(posedge clk_sys);
    chk(16'(pin_timer_sel), 16'h0000);
    chk(16'(pin_out), 16'h0015);
    cur_mask <= 5'h01;
    send(rows[0].cmd, rej);
    chk(16'({rej, pin_timer_sel[0]}), 16'h0001);
    // ==========================================
    // Standby entry and exit
    standby_req <= 1'b1;
    for (int n = 0; n < 200 && standby_en !== 1'b1; n++) @(posedge clk_sys);
    @(posedge clk_sys);
    for (int j = 0; j < 5; j++) chk(16'(DEV.regs[6'h30 + 6'(j)]), 16'h0000);
    chk(16'(DEV.wave), 16'h0000);
    chk_flag(cmd_ready, 1'b0);
    standby_req <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk_flag(standby_en, 1'b0);
    // ==========================================
    // Reset in mid-command
    cmd <= rows[3].cmd;
    cmd_valid <= 1'b1;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b1;
    cmd_valid <= 1'b0;
    @(posedge clk_sys);
    chk(16'({standby_en, dev_wr_valid, pin_timer_sel}), 16'h0000);
    for (int j = 0; j < 5; j++) chk(16'(DEV.regs[6'h10 + 6'(j)]), 16'h0000);
    chk(16'(pin_out), 16'(port_level));
    reset <= 1'b0;
    send(rows[0].cmd, rej);
    chk_flag(rej, 1'b0);
    summarize();
  end
endmodule // test_mft_init_ctrl
